// ---- logic/iopdi_port.sv ----
// Top of the isolated output port: register decode, channel outputs,
// settling-delay interrupt and the bit-banged identification serial port.
// Assumes bus strobes are already synchronous to core_clk, one cycle each.
//
// Behaviour
// R1: Host bus carries 16-bit words and an interrupt request to the carrier.
// R2: Registers decode at 00, 02, 04, 12, 14 and FE; others read zero.
// R3: Output bit n closes channel n when 1; reads return channel settings.
// R4: Interrupt is raised after a channel command, once the settling delay ends.
// R5: Delay equals (register value plus one) time units; register is write-only.
// R6: After reset the delay is 13 ms until software changes it.
// R7: One delay setting covers all sixteen channels.
// R8: Status bit 7 reads 0 while delay runs, 1 after it elapsed.
// R9: Pending flag is bit 0 of status and interrupt registers.
// R10: Control bit 1 enables the delay interrupt; reads back as written.
// R11: Writing 1 to control bit 0 starts a soft reset; bit readable.
// R12: Serial port write bit 1 drives the EEPROM clock pin.
// R13: Serial port write bit 2 drives chip select; bit 0 drives data.
// R14: Serial port reads give data-out in bit 0, ones in 15..8.
// R15: The identification EEPROM outside holds 64 words of 16 bits.
// R16: Host software should not write data through serial port bit 0.
// R17: Interrupt request is withdrawn during the interrupt acknowledge cycle.
// R18: Output write sets busy and restarts delay; expiry with enable sets pending.
// R19: Writing 1 to interrupt bit 0 clears pending; writing 0 leaves it.
`timescale 1ns/1ps
module iopdi_port (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire iopdi_pkg::iopdi_req_s  bus_req,
   output logic [15:0]                 bus_rdata,
   output logic                        bus_ack,
   output logic                        irq_req,
   output logic [15:0]                 channel_close_bits,
   output iopdi_pkg::iopdi_ee_s        ee_pins,
   input  wire logic                   ee_data_out
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic logic hit(input iopdi_pkg::iopdi_req_s r, input logic [7:0] off);
      hit = r.cs && !r.iack && r.addr == off;
   endfunction

   logic wr_ctrl;
   logic wr_irq;
   logic wr_dly;
   logic wr_out;
   logic wr_ee;
   assign wr_ctrl = bus_req.wr && hit(bus_req, iopdi_pkg::OFF_PORT_CONTROL);
   assign wr_irq  = bus_req.wr && hit(bus_req, iopdi_pkg::OFF_INTERRUPT_PENDING);
   assign wr_dly  = bus_req.wr && hit(bus_req, iopdi_pkg::OFF_SETTLE_DELAY);
   assign wr_out  = bus_req.wr && hit(bus_req, iopdi_pkg::OFF_CHANNEL_OUTPUTS);
   assign wr_ee   = bus_req.wr && hit(bus_req, iopdi_pkg::OFF_ID_SERIAL_PORT);

   // ----------------------------------------------------------------
   // Soft reset
   // ----------------------------------------------------------------
   // A soft reset stretches over a few cycles so the request bit reads
   // back as 1 briefly; the host sees it clear itself.
   logic [2:0] soft_reset_request_cnt_q;
   logic [2:0] soft_reset_request_cnt_d;
   logic       soft_reset_request;
   logic       lrst_n;

   always_comb begin
      soft_reset_request_cnt_d = soft_reset_request_cnt_q;
      if (wr_ctrl && bus_req.wdata[iopdi_pkg::CTRL_SOFT_RESET_REQUEST_BIT]) begin
         soft_reset_request_cnt_d = 3'(iopdi_pkg::SOFT_RESET_REQUEST_CYCLES); // R11
      end else if (soft_reset_request_cnt_q != 3'h0) begin
         soft_reset_request_cnt_d = soft_reset_request_cnt_q - 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         soft_reset_request_cnt_q <= 3'h0;
      end else begin
         soft_reset_request_cnt_q <= soft_reset_request_cnt_d;
      end
   end

   assign soft_reset_request = soft_reset_request_cnt_q != 3'h0;
   assign lrst_n = rst_n && !soft_reset_request; // R11

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic        delay_irq_enable_q;
   logic        delay_irq_enable_d;
   logic [15:0] settle_delay_value_q;
   logic [15:0] settle_delay_value_d;
   logic [15:0] out_q;
   logic [15:0] out_d;
   iopdi_pkg::iopdi_ee_s ee_q;
   iopdi_pkg::iopdi_ee_s ee_d;

   always_comb begin
      delay_irq_enable_d   = delay_irq_enable_q;
      settle_delay_value_d = settle_delay_value_q;
      out_d                = out_q;
      ee_d                 = ee_q;
      if (wr_ctrl) begin
         delay_irq_enable_d = bus_req.wdata[iopdi_pkg::CTRL_IEN_BIT]; // R10
      end
      if (wr_dly) begin
         settle_delay_value_d = bus_req.wdata; // R5 R7
      end
      if (wr_out) begin
         out_d = bus_req.wdata; // R3
      end
      if (wr_ee) begin
         ee_d.cs  = bus_req.wdata[iopdi_pkg::EE_CS_BIT];   // R13
         ee_d.clk = bus_req.wdata[iopdi_pkg::EE_CLK_BIT];  // R12
         ee_d.din = bus_req.wdata[iopdi_pkg::EE_DATA_BIT]; // R13 R16
      end
   end

   always_ff @(posedge core_clk) begin
      if (!lrst_n) begin
         delay_irq_enable_q   <= 1'b0;
         settle_delay_value_q <= iopdi_pkg::DELAY_RESET; // R6
         out_q                <= iopdi_pkg::OUT_RESET;
         ee_q                 <= '0;
      end else begin
         delay_irq_enable_q   <= delay_irq_enable_d;
         settle_delay_value_q <= settle_delay_value_d;
         out_q                <= out_d;
         ee_q                 <= ee_d;
      end
   end

   assign channel_close_bits = out_q; // R3
   assign ee_pins            = ee_q;

   // ----------------------------------------------------------------
   // Settling timer
   // ----------------------------------------------------------------
   logic tick;
   logic running;
   logic expire;

   // The time unit is cut to a whole number of core cycles, so each tick is
   // half a cycle short; over the longest delay that stays below 0.02 percent.
   // Restarting the divider with the counter makes the first tick a full time
   // unit after the write, so a zero delay never fires early.
   iopdi_tick u_tick (
      .core_clk (core_clk),
      .rst_n    (lrst_n),
      .restart  (wr_out),
      .tick     (tick)
   );

   iopdi_timer u_timer (
      .core_clk    (core_clk),
      .rst_n       (lrst_n),
      .start       (wr_out), // R18 R4
      .tick        (tick),
      .delay_value (settle_delay_value_q),
      .running     (running),
      .expire      (expire)
   );

   // ----------------------------------------------------------------
   // Pending flag and request line
   // ----------------------------------------------------------------
   // An acknowledge clears the flag as well, so a carrier that never writes
   // the interrupt register still sees exactly one request per expiry.
   logic delay_irq_pending_q;
   logic delay_irq_pending_d;

   always_comb begin
      delay_irq_pending_d = delay_irq_pending_q;
      if (wr_irq && bus_req.wdata[iopdi_pkg::IRQ_PENDING_BIT]) begin
         delay_irq_pending_d = 1'b0; // R19
      end
      if (bus_req.cs && bus_req.iack && delay_irq_pending_q) begin
         delay_irq_pending_d = 1'b0; // R17
      end
      // Expiry wins over a simultaneous clear so no event is lost.
      if (expire && delay_irq_enable_q) begin
         delay_irq_pending_d = 1'b1; // R4 R18
      end
   end

   always_ff @(posedge core_clk) begin
      if (!lrst_n) begin
         delay_irq_pending_q <= 1'b0;
      end else begin
         delay_irq_pending_q <= delay_irq_pending_d;
      end
   end

   // The request drops combinationally during an acknowledge cycle.
   assign irq_req = delay_irq_pending_q && delay_irq_enable_q
                    && !(bus_req.cs && bus_req.iack); // R1 R10 R17

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Reads of write-only and reserved offsets return zeros. A read has no
   // side effects, so the host may poll status as often as it likes.
   logic [15:0] rdata_d;
   logic [15:0] rdata_q;
   logic        ack_q;

   always_comb begin
      rdata_d = 16'h0000; // R2
      if (bus_req.cs && bus_req.iack) begin
         rdata_d = 16'h0000;
      end else if (bus_req.cs && !bus_req.wr) begin
         unique case (bus_req.addr)
            iopdi_pkg::OFF_PORT_STATUS: begin
               rdata_d[iopdi_pkg::STAT_SETTLED_BIT] = !running; // R8
               rdata_d[iopdi_pkg::STAT_PENDING_BIT] = delay_irq_pending_q; // R9
            end
            iopdi_pkg::OFF_PORT_CONTROL: begin
               rdata_d[iopdi_pkg::CTRL_IEN_BIT]  = delay_irq_enable_q;
               rdata_d[iopdi_pkg::CTRL_SOFT_RESET_REQUEST_BIT] = soft_reset_request;
            end
            iopdi_pkg::OFF_INTERRUPT_PENDING: begin
               rdata_d[iopdi_pkg::IRQ_PENDING_BIT] = delay_irq_pending_q; // R9
            end
            iopdi_pkg::OFF_CHANNEL_OUTPUTS: begin
               rdata_d = out_q; // R3
            end
            iopdi_pkg::OFF_ID_SERIAL_PORT: begin
               rdata_d = iopdi_pkg::EE_READ_ONES; // R14 R15
               rdata_d[iopdi_pkg::EE_DATA_BIT] = ee_data_out;
            end
            default: begin
               rdata_d = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
         ack_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ack_q   <= bus_req.cs;
      end
   end

   assign bus_rdata = rdata_q;
   assign bus_ack   = ack_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_OUT_FOLLOWS: assert property (@(posedge core_clk) disable iff (!lrst_n) // R3
      wr_out |=> channel_close_bits == $past(bus_req.wdata))
      else $error("channel outputs did not take written value");
   AST_BUSY_ON_WRITE: assert property (@(posedge core_clk) disable iff (!lrst_n) // R18
      wr_out |=> running)
      else $error("timer not running after output write");
   AST_MIN_DELAY: assert property (@(posedge core_clk) disable iff (!lrst_n) // R5
      wr_out |=> !expire [*8])
      else $error("delay expired too early");
   AST_PEND_SET: assert property (@(posedge core_clk) disable iff (!lrst_n) // R4
      (expire && delay_irq_enable_q) |=> delay_irq_pending_q)
      else $error("pending not set on expiry");
   AST_NO_IRQ_DIS: assert property (@(posedge core_clk) disable iff (!lrst_n) // R10
      !delay_irq_enable_q |-> !irq_req)
      else $error("interrupt driven while disabled");
   AST_CLEAR: assert property (@(posedge core_clk) disable iff (!lrst_n) // R19
      (wr_irq && bus_req.wdata[0] && !expire) |=> !delay_irq_pending_q)
      else $error("pending not cleared by write of one");
   AST_IACK_DROP: assert property (@(posedge core_clk) disable iff (!lrst_n) // R17
      (bus_req.cs && bus_req.iack) |-> !irq_req)
      else $error("request held during acknowledge");
   AST_EE_READ: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
      (bus_req.cs && !bus_req.wr && !bus_req.iack
       && bus_req.addr == iopdi_pkg::OFF_ID_SERIAL_PORT)
      |=> bus_rdata[15:1] == 15'h7f80)
      else $error("serial port read pattern wrong");
   AST_SOFT_RESET_REQUEST_RESET: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
      (wr_ctrl && bus_req.wdata[0]) |=> ##1 channel_close_bits == 16'h0000)
      else $error("soft reset did not clear outputs");

   // The ack, status and pending read checks below watch the bus answers. They use the hard reset only,
   // because the answer flops keep running through a soft reset.
   AST_DELAY_DEFAULT: assert property (@(posedge core_clk) // R6
      !lrst_n |=> settle_delay_value_q == 16'h0197)
      else $error("delay register not at its default after reset");
   AST_ACK_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
      bus_req.cs |=> bus_ack)
      else $error("access not answered one cycle later");
   AST_BUSY_READ: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
      (bus_req.cs && !bus_req.wr && !bus_req.iack
       && bus_req.addr == iopdi_pkg::OFF_PORT_STATUS)
      |=> bus_rdata[iopdi_pkg::STAT_SETTLED_BIT] == !$past(running))
      else $error("status settled bit does not follow the timer");
   AST_PEND_READ: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
      (bus_req.cs && !bus_req.wr && !bus_req.iack
       && (bus_req.addr == iopdi_pkg::OFF_PORT_STATUS
           || bus_req.addr == iopdi_pkg::OFF_INTERRUPT_PENDING))
      |=> bus_rdata[0] == $past(delay_irq_pending_q))
      else $error("pending flag not shown in status or interrupt read");
   AST_EE_PINS: assert property (@(posedge core_clk) disable iff (!lrst_n) // R12 R13
      wr_ee |=> ee_pins == $past(bus_req.wdata[2:0]))
      else $error("serial port pins did not take written bits");
   AST_CHAN_HOLD: assert property (@(posedge core_clk) disable iff (!lrst_n) // R3
      !wr_out |=> $stable(channel_close_bits))
      else $error("channel outputs changed without a write");
endmodule

// ---- logic/iopdi_pkg.sv ----
// Package for the isolated output port with settling-delay interrupt.
// Assumes a 100 MHz core clock and the register offsets of the I/O space.
package iopdi_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses within the I/O space)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_PORT_STATUS       = 8'h00;
   localparam logic [7:0] OFF_PORT_CONTROL      = 8'h02;
   localparam logic [7:0] OFF_INTERRUPT_PENDING = 8'h04;
   localparam logic [7:0] OFF_SETTLE_DELAY      = 8'h12;
   localparam logic [7:0] OFF_CHANNEL_OUTPUTS   = 8'h14;
   localparam logic [7:0] OFF_ID_SERIAL_PORT    = 8'hfe;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int STAT_PENDING_BIT = 0;
   localparam int STAT_SETTLED_BIT = 7;
   localparam int CTRL_SOFT_RESET_REQUEST_BIT    = 0;
   localparam int CTRL_IEN_BIT     = 1;
   localparam int IRQ_PENDING_BIT  = 0;
   localparam int EE_DATA_BIT      = 0;
   localparam int EE_CLK_BIT       = 1;
   localparam int EE_CS_BIT        = 2;
   localparam logic [15:0] EE_READ_ONES = 16'hff00;

   // ----------------------------------------------------------------
   // Timing: one delay tick is 0.031875 ms, default delay 13 ms
   // ----------------------------------------------------------------
   localparam int  CLK_PERIOD_PS   = 10000;
   localparam int  TICK_PS         = 31875000;
   localparam int  TICK_CYCLES     = TICK_PS / CLK_PERIOD_PS;
   localparam int  TICK_NS         = TICK_PS / 1000;
   localparam int  DEFAULT_DELAY_US = 13000;
   // Worked in nanoseconds so the product stays inside 32 bits; rounded up so
   // the default delay is never shorter than 13 ms.
   localparam int  DEFAULT_TICKS   = (DEFAULT_DELAY_US * 1000 + TICK_NS - 1) / TICK_NS;
   localparam logic [15:0] DELAY_RESET = 16'(DEFAULT_TICKS - 1);
   localparam logic [15:0] OUT_RESET   = 16'h0000;
   localparam int  SOFT_RESET_REQUEST_CYCLES     = 4;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       cs;
      logic       wr;
      logic       iack;
      logic [7:0] addr;
      logic [15:0] wdata;
   } iopdi_req_s;

   typedef struct packed {
      logic        cs;
      logic        clk;
      logic        din;
   } iopdi_ee_s;

endpackage

// ---- logic/iopdi_tick.sv ----
// Divider that gives one-cycle time-unit ticks for the settling timer.
// Assumes the core clock of the package; restarts on demand.
`timescale 1ns/1ps
module iopdi_tick (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic restart,
   output logic      tick
);
   localparam int W = $clog2(iopdi_pkg::TICK_CYCLES);
   localparam logic [W-1:0] LAST = W'(iopdi_pkg::TICK_CYCLES - 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q + W'(1);
      if (restart || cnt_q == LAST) begin
         cnt_d = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign tick = !restart && (cnt_q == LAST);
endmodule

// ---- logic/iopdi_timer.sv ----
// Settling-delay counter: counts (value + 1) time-unit ticks after a start.
// Assumes tick pulses from the divider, restarted together with this counter.
`timescale 1ns/1ps
module iopdi_timer (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        start,
   input  wire logic        tick,
   input  wire logic [15:0] delay_value,
   output logic             running,
   output logic             expire
);
   logic [16:0] left_q;
   logic [16:0] left_d;
   logic        run_q;
   logic        run_d;

   always_comb begin
      left_d = left_q;
      run_d  = run_q;
      if (start) begin
         left_d = {1'b0, delay_value} + 17'h00001;
         run_d  = 1'b1;
      end else if (run_q && tick) begin
         left_d = left_q - 17'h00001;
         if (left_q == 17'h00001) begin
            run_d = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         left_q <= '0;
         run_q  <= 1'b0;
      end else begin
         left_q <= left_d;
         run_q  <= run_d;
      end
   end

   assign running = run_q;
   assign expire  = run_q && tick && !start && left_q == 17'h00001;
endmodule

// ---- verification/iopdi_ee_model.sv ----
// Behavioural identification EEPROM seen through the serial port pins.
// Assumes the pins are registered by the port and sampled on core_clk.
`timescale 1ns/1ps
module iopdi_ee_model #(
   parameter logic [15:0] ID_WORD = 16'h5a3c  // Arbitrary content word.
) (
   input  wire logic                 core_clk,
   input  wire iopdi_pkg::iopdi_ee_s pins,
   output logic                      data_out
);
   // ----------------------------------------------------------------
   // Shift state
   // ----------------------------------------------------------------
   // One 16-bit word stands in for the 64-word store; it is shifted out
   // one bit per rising serial clock while selected.
   logic [3:0] idx_q;
   logic       clk_q;
   logic       last_q;

   initial begin
      idx_q = 4'h0;
      clk_q = 1'b0;
      last_q = 1'b0;
   end

   always @(posedge core_clk) begin
      clk_q <= pins.clk;
      if (pins.cs && pins.clk && !clk_q) begin
         idx_q <= idx_q + 4'h1;
         last_q <= ID_WORD[idx_q];
      end
   end

   // A deselected part no longer shows its last bit.
   assign data_out = pins.cs ? last_q : ~last_q;
endmodule

// ---- verification/isolated_output_port_delay_irq_tb.sv ----
// Self-checking bench for the isolated output port and its delay timer.
// Assumes the one-cycle strobe bus and fixed answer latency of the port.
`timescale 1ns/1ps
module isolated_output_port_delay_irq_tb;
   logic                  core_clk;
   logic                  rst_n;
   iopdi_pkg::iopdi_req_s req;
   logic [15:0]           bus_rdata;
   logic                  bus_ack;
   logic                  irq_req;
   logic [15:0]           channel_close_bits;
   iopdi_pkg::iopdi_ee_s  ee_pins;
   logic                  ee_data_out;
   logic [15:0]           rv;
   int                    err_total;
   int                    checks_done;
   int                    n;

   iopdi_port uut (
      .core_clk           (core_clk),
      .rst_n              (rst_n),
      .bus_req            (req),
      .bus_rdata          (bus_rdata),
      .bus_ack            (bus_ack),
      .irq_req            (irq_req),
      .channel_close_bits (channel_close_bits),
      .ee_pins            (ee_pins),
      .ee_data_out        (ee_data_out)
   );

   iopdi_ee_model ee (
      .core_clk (core_clk),
      .pins     (ee_pins),
      .data_out (ee_data_out)
   );

   always #5 core_clk = ~core_clk;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      req <= '{cs: 1'b1, wr: w, iack: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      req.cs <= 1'b0;
      #1;
      chk("ack", 16'h1, {15'h0, bus_ack});
      rv = bus_rdata;
   endtask

   task automatic wait_irq();
      n = 0;
      while (irq_req !== 1'b1 && n < 14000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask

   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_map();
      logic [7:0] gaps [5] = '{8'h06, 8'h0e, 8'h10, 8'h16, 8'hfc};
      acc(0, 8'h00, 16'h0);
      chk("status", 16'h0080, rv);
      acc(1, 8'h00, 16'hffff);
      acc(0, 8'h00, 16'h0);
      chk("status_ro", 16'h0080, rv);
      acc(1, 8'h12, 16'h1234);
      acc(0, 8'h12, 16'h0);
      chk("delay_wo", 16'h0000, rv);
      foreach (gaps[i]) begin
         acc(1, gaps[i], 16'hffff);
         acc(0, gaps[i], 16'h0);
         chk("unmapped", 16'h0000, rv);
      end
      acc(1, 8'h14, 16'h8001);
      chk("chan", 16'h8001, channel_close_bits);
      acc(0, 8'h14, 16'h0);
      chk("chan_rd", 16'h8001, rv);
   endtask

   task automatic t_timer();
      acc(1, 8'h12, 16'h0000);
      acc(1, 8'h02, 16'h0002);
      acc(0, 8'h02, 16'h0);
      chk("ctrl_rd", 16'h0002, rv);
      acc(1, 8'h14, 16'ha5a5);
      acc(0, 8'h00, 16'h0);
      chk("busy", 16'h0000, rv);
      wait_irq();
      chk("delay0", 16'h1, {15'h0, n >= 3183 && n <= 3192});
      acc(0, 8'h00, 16'h0);
      chk("st_pend", 16'h0081, rv);
      acc(1, 8'h04, 16'h0000);
      acc(0, 8'h04, 16'h0);
      chk("pend_keep", 16'h0001, rv);
      acc(1, 8'h04, 16'h0001);
      acc(0, 8'h04, 16'h0);
      chk("pend_clr", 16'h0000, rv);
      chk("irq_off", 16'h0, {15'h0, irq_req});
   endtask

   task automatic t_disabled();
      acc(1, 8'h02, 16'h0000);
      acc(1, 8'h14, 16'h0ff0);
      repeat (3300) @(posedge core_clk);
      #1;
      chk("irq_dis", 16'h0, {15'h0, irq_req});
      acc(0, 8'h00, 16'h0);
      chk("st_dis", 16'h0080, rv);
   endtask

   task automatic t_iack();
      acc(1, 8'h12, 16'h0001);
      acc(1, 8'h02, 16'h0002);
      acc(1, 8'h14, 16'h5a00);
      wait_irq();
      chk("delay1", 16'h1, {15'h0, n >= 6370 && n <= 6379});
      @(posedge core_clk);
      req <= '{cs: 1'b1, wr: 1'b0, iack: 1'b1, addr: 8'h00, wdata: 16'h0};
      #1;
      chk("iack_live", 16'h0, {15'h0, irq_req});
      @(posedge core_clk);
      req.cs <= 1'b0;
      req.iack <= 1'b0;
      #1;
      chk("iack_irq", 16'h0, {15'h0, irq_req});
      acc(0, 8'h04, 16'h0);
      chk("iack_pend", 16'h0, rv);
   endtask

   task automatic t_serial();
      // Data bit 0 is kept low so the identification store is never written.
      for (int v = 0; v < 8; v += 2) begin
         acc(1, 8'hfe, 16'(v));
         chk("ee_pins", 16'(v), {13'h0, ee_pins.cs, ee_pins.clk, ee_pins.din});
         acc(0, 8'hfe, 16'h0);
         // Deselected, the model shows the inverse of its cleared last bit;
         // selected, it shows its cleared last bit, then the first stored bit; both are zero.
         chk("ee_rd", {8'hff, 7'h0, 1'(v < 4)}, rv);
      end
   endtask

   task automatic t_soft_reset();
      acc(1, 8'h14, 16'hffff);
      acc(1, 8'h02, 16'h0003);
      acc(0, 8'h02, 16'h0);
      chk("soft_reset_request_rd", 16'h1, {15'h0, rv[0]});
      repeat (6) @(posedge core_clk);
      #1;
      chk("soft_reset_request_chan", 16'h0000, channel_close_bits);
      acc(0, 8'h02, 16'h0);
      chk("soft_reset_request_ctrl", 16'h0000, rv);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      req = '0;
      err_total = 0;
      checks_done = 0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      chk("irq_rst", 16'h0, {15'h0, irq_req});
      t_reset_map();
      t_timer();
      t_disabled();
      t_iack();
      t_serial();
      t_soft_reset();
      give_verdict();
   end

   initial begin
      #400us;
      err_total++;
      give_verdict();
   end
endmodule
